/* src/hrbs_defs.vh */
// Purpose: Shared constants of the harmonic ratio blocking stage
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   Definitions only
`ifndef HRBS_DEFS_VH
`define HRBS_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define HRBS_OFS_EVT_ENABLE   8'h00
`define HRBS_OFS_THRESHOLD    8'h04
`define HRBS_OFS_DELAY        8'h08
`define HRBS_OFS_STATUS       8'h0C
`define HRBS_OFS_EVENTS       8'h10
`define HRBS_OFS_PHASE_A      8'h14
`define HRBS_OFS_PHASE_B      8'h18
`define HRBS_OFS_PHASE_C      8'h1C
`define HRBS_OFS_FAULT_MAX    8'h20
`define HRBS_OFS_ELAPSED      8'h24

////////////////////////////////////////////////////////////////////////////////
// Event bit positions (enable and sticky registers share them)
`define HRBS_EVT_START_ON     0
`define HRBS_EVT_START_OFF    1
`define HRBS_EVT_TRIP_ON      2
`define HRBS_EVT_TRIP_OFF     3

// Status bit positions
`define HRBS_ST_START         0
`define HRBS_ST_TRIP          1
`define HRBS_ST_HARM_LSB      4

////////////////////////////////////////////////////////////////////////////////
// Reset values and limits
`define HRBS_RST_EVT_ENABLE   4'hF
`define HRBS_THR_MIN_PCT      7'h0A
`define HRBS_THR_MAX_PCT      7'h64
`define HRBS_RST_THRESHOLD    7'h0A
`define HRBS_PCT_FULL         16'h0064

////////////////////////////////////////////////////////////////////////////////
// Timing: delay register counts 10 ms ticks
`define HRBS_TICK_MS          10
`define HRBS_CLK_KHZ          200000
`define HRBS_TICK_CYCLES      (`HRBS_TICK_MS * `HRBS_CLK_KHZ)
`define HRBS_DLY_MIN_TICKS    15'h0005
`define HRBS_DLY_MAX_TICKS    15'h7530
`define HRBS_RST_DELAY        15'h0005

`endif

/* src/hrbs_div.v */
// Purpose: Serial restoring divider, one quotient bit per clock
// Assumes: Divisor is nonzero when go is raised
// Notes:   go is ignored while busy
`timescale 1ns/100ps

module hrbs_div #(
   parameter W = 24
) (
   // Clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // Request
   input  wire         go,
   input  wire [W-1:0] num,
   input  wire [W-1:0] den,
   // Answer
   output reg          busy,
   output reg          done,
   output reg  [W-1:0] quo
);

   reg [W-1:0] rem;
   reg [W-1:0] dvs;
   reg [W-1:0] cnt;
   localparam [W-1:0] CNT_INIT = W;
   wire [W:0]  trial = {rem[W-1:0], quo[W-1]} - {1'b0, dvs};

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         done <= 1'b0;
         quo  <= {W{1'b0}};
         rem  <= {W{1'b0}};
         dvs  <= {W{1'b0}};
         cnt  <= {W{1'b0}};
      end else begin
         done <= 1'b0;
         if (!busy) begin
            if (go) begin
               busy <= 1'b1;
               quo  <= num;
               rem  <= {W{1'b0}};
               dvs  <= den;
               cnt  <= CNT_INIT;
            end
         end else begin
            // Shift a dividend bit in, keep the difference when it fits
            if (!trial[W]) begin
               rem <= trial[W-1:0];
               quo <= {quo[W-2:0], 1'b1};
            end else begin
               rem <= {rem[W-2:0], quo[W-1]};
               quo <= {quo[W-2:0], 1'b0};
            end
            cnt <= cnt - 1'b1;
            if (cnt == 1) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

endmodule // hrbs_div

/* src/hrbs_stage.v */
// Purpose: Harmonic to fundamental ratio stage with start, delayed trip and event log
// Assumes: Measurement strobe and magnitudes come from logic on pclk
// Notes:   HARMONIC selects the inrush (2) or overexcitation (5) variant
`timescale 1ns/100ps
`include "hrbs_defs.vh"

// Function
// - Per-phase harmonic to fundamental ratio evaluation
// - Start while any phase exceeds threshold
// - Trip after definite delay from start
// - Threshold 10 to 100 percent, default 10
// - Delay 0.05 to 300 s, default 0.05
// - Four event reports, each enabled by default
// - Start and trip offered as blocking outputs
// - Fifth-harmonic variant behaves identically
// - Per-phase harmonic percentage readable
// - Maximum fault ratio recorded in percent
// - Elapsed delay recorded, 100 percent means trip
module hrbs_stage #(
   parameter HARMONIC    = 2,
   parameter TICK_CYCLES = `HRBS_TICK_CYCLES
) (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg         pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   // Harmonic measurement
   input  wire        meas_valid,
   input  wire [15:0] harm_a,
   input  wire [15:0] harm_b,
   input  wire [15:0] harm_c,
   input  wire [15:0] fund_a,
   input  wire [15:0] fund_b,
   input  wire [15:0] fund_c,
   // Blocking outputs and event reports
   output reg         start_out,
   output reg         trip_out,
   output reg         evt_start_on,
   output reg         evt_start_off,
   output reg         evt_trip_on,
   output reg         evt_trip_off
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function [15:0] sat16;
      input [23:0] v;
      begin
         sat16 = (v[23:16] != 8'h00) ? 16'hFFFF : v[15:0];
      end
   endfunction

   function [23:0] times100;
      input [15:0] v;
      begin
         times100 = {2'b00, v, 6'h00} + {3'b000, v, 5'h00} + {6'h00, v, 2'b00};
      end
   endfunction

   localparam [3:0]  HARM_CODE = HARMONIC;
   localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   reg  [3:0]  evt_enable;
   reg  [6:0]  second_harmonic_threshold;
   reg  [14:0] inrush_operate_delay;
   reg  [3:0]  events;
   reg  [15:0] phase_a_pct;
   reg  [15:0] phase_b_pct;
   reg  [15:0] phase_c_pct;
   reg  [15:0] fault_max_pct;
   reg  [15:0] run_max_pct;
   reg  [15:0] elapsed_delay_pct;
   reg  [31:0] tick_cnt;
   reg  [14:0] delay_ticks;
   reg  [2:0]  fund_zero;
   reg         elapsed_delay_pct_busy_q;

   wire [23:0] quo_a;
   wire [23:0] quo_b;
   wire [23:0] quo_c;
   wire [23:0] quo_e;
   wire        busy_a;
   wire        busy_b;
   wire        busy_c;
   wire        busy_e;
   wire        done_a;
   wire        done_b;
   wire        done_c;
   wire        done_e;

   wire        ph_go = meas_valid & ~busy_a & ~busy_b & ~busy_c;
   wire        wr_en = psel & penable & pready & pwrite;
   wire [15:0] thr16 = {9'h000, second_harmonic_threshold};
   wire        over  = (phase_a_pct > thr16) | (phase_b_pct > thr16) |
                       (phase_c_pct > thr16);
   wire        tick  = (tick_cnt == TICK_LAST);
   wire        delay_done = (delay_ticks >= inrush_operate_delay);
   wire [15:0] cur_max = (phase_a_pct > phase_b_pct) ?
                         ((phase_a_pct > phase_c_pct) ? phase_a_pct : phase_c_pct) :
                         ((phase_b_pct > phase_c_pct) ? phase_b_pct : phase_c_pct);
   wire [15:0] next_pct_a = fund_zero[0] ? 16'h0000 : sat16(quo_a);
   wire [15:0] next_pct_b = fund_zero[1] ? 16'h0000 : sat16(quo_b);
   wire [15:0] next_pct_c = fund_zero[2] ? 16'h0000 : sat16(quo_c);
   // Fault end is the cycle in which start still stands but the excess is gone
   wire        start_fall = start_out & ~over;
   wire        elapsed_delay_pct_go = start_fall & ~busy_e;

   ////////////////////////////////////////////////////////////////////////////
   // Ratio dividers, one per phase; a strobe that arrives mid-division is dropped
   hrbs_div #(.W(24)) u_div_a (
      .pclk    (pclk),
      .presetn (presetn),
      .go      (ph_go),
      .num     (times100(harm_a)),
      .den     ({8'h00, fund_a}),
      .busy    (busy_a),
      .done    (done_a),
      .quo     (quo_a)
   );

   hrbs_div #(.W(24)) u_div_b (
      .pclk    (pclk),
      .presetn (presetn),
      .go      (ph_go),
      .num     (times100(harm_b)),
      .den     ({8'h00, fund_b}),
      .busy    (busy_b),
      .done    (done_b),
      .quo     (quo_b)
   );

   hrbs_div #(.W(24)) u_div_c (
      .pclk    (pclk),
      .presetn (presetn),
      .go      (ph_go),
      .num     (times100(harm_c)),
      .den     ({8'h00, fund_c}),
      .busy    (busy_c),
      .done    (done_c),
      .quo     (quo_c)
   );

   // Elapsed delay divider, run once at the end of each fault
   hrbs_div #(.W(24)) u_div_e (
      .pclk    (pclk),
      .presetn (presetn),
      .go      (elapsed_delay_pct_go),
      .num     (times100({1'b0, delay_ticks})),
      .den     ({9'h000, inrush_operate_delay}),
      .busy    (busy_e),
      .done    (done_e),
      .quo     (quo_e)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Measured ratios
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fund_zero   <= 3'b000;
         phase_a_pct <= 16'h0000;
         phase_b_pct <= 16'h0000;
         phase_c_pct <= 16'h0000;
      end else begin
         if (ph_go)
            fund_zero <= {fund_c == 16'h0000, fund_b == 16'h0000, fund_a == 16'h0000};
         // Zero fundamental means no current, so no harmonic excess
         if (done_a)
            phase_a_pct <= next_pct_a;
         if (done_b)
            phase_b_pct <= next_pct_b;
         if (done_c)
            phase_c_pct <= next_pct_c;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start, delay timer and trip
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_out   <= 1'b0;
         trip_out    <= 1'b0;
         tick_cnt    <= 32'h00000000;
         delay_ticks <= 15'h0000;
      end else if (!over) begin
         start_out   <= 1'b0;
         trip_out    <= 1'b0;
         tick_cnt    <= 32'h00000000;
         if (!start_out)
            delay_ticks <= 15'h0000;
      end else begin
         start_out <= 1'b1;
         if (!start_out) begin
            tick_cnt    <= 32'h00000000;
            delay_ticks <= 15'h0000;
         end else if (!delay_done) begin
            tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
            if (tick)
               delay_ticks <= delay_ticks + 15'h0001;
         end
         // Delay compare also catches a delay shortened during a fault
         if (start_out && delay_done)
            trip_out <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault records
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_max_pct       <= 16'h0000;
         fault_max_pct     <= 16'h0000;
         elapsed_delay_pct <= 16'h0000;
         elapsed_delay_pct_busy_q       <= 1'b0;
      end else begin
         if (over && !start_out)
            run_max_pct <= cur_max;
         else if (start_out && cur_max > run_max_pct)
            run_max_pct <= cur_max;
         if (start_fall)
            fault_max_pct <= run_max_pct;
         elapsed_delay_pct_busy_q <= busy_e;
         if (done_e)
            elapsed_delay_pct <= (sat16(quo_e) > `HRBS_PCT_FULL) ?
                                 `HRBS_PCT_FULL : sat16(quo_e);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event reports: pulses plus sticky bits; a new event beats a clear
   wire [3:0] evt_raw;
   assign evt_raw[`HRBS_EVT_START_ON]  = over & ~start_out;
   assign evt_raw[`HRBS_EVT_START_OFF] = ~over & start_out;
   assign evt_raw[`HRBS_EVT_TRIP_ON]   = over & start_out & delay_done & ~trip_out;
   assign evt_raw[`HRBS_EVT_TRIP_OFF]  = ~over & trip_out;
   wire [3:0] evt_hit = evt_raw & evt_enable;
   wire [3:0] evt_clr = (wr_en && paddr == `HRBS_OFS_EVENTS) ? pwdata[3:0] : 4'h0;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         events        <= 4'h0;
         evt_start_on  <= 1'b0;
         evt_start_off <= 1'b0;
         evt_trip_on   <= 1'b0;
         evt_trip_off  <= 1'b0;
      end else begin
         events        <= (events & ~evt_clr) | evt_hit;
         evt_start_on  <= evt_hit[`HRBS_EVT_START_ON];
         evt_start_off <= evt_hit[`HRBS_EVT_START_OFF];
         evt_trip_on   <= evt_hit[`HRBS_EVT_TRIP_ON];
         evt_trip_off  <= evt_hit[`HRBS_EVT_TRIP_OFF];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settings; writes outside the legal range are ignored
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_enable                <= `HRBS_RST_EVT_ENABLE;
         second_harmonic_threshold <= `HRBS_RST_THRESHOLD;
         inrush_operate_delay      <= `HRBS_RST_DELAY;
      end else if (wr_en) begin
         case (paddr)
            `HRBS_OFS_EVT_ENABLE: evt_enable <= pwdata[3:0];
            `HRBS_OFS_THRESHOLD: begin
               if (pwdata[31:7] == 25'h0000000 &&
                   pwdata[6:0] >= `HRBS_THR_MIN_PCT && pwdata[6:0] <= `HRBS_THR_MAX_PCT)
                  second_harmonic_threshold <= pwdata[6:0];
            end
            `HRBS_OFS_DELAY: begin
               if (pwdata[31:15] == 17'h00000 &&
                   pwdata[14:0] >= `HRBS_DLY_MIN_TICKS && pwdata[14:0] <= `HRBS_DLY_MAX_TICKS)
                  inrush_operate_delay <= pwdata[14:0];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB: zero wait states, read data captured in the setup cycle
   reg [31:0] next_prdata;
   reg        next_err;

   always @* begin
      next_prdata = 32'h00000000;
      next_err    = 1'b0;
      case (paddr)
         `HRBS_OFS_EVT_ENABLE: next_prdata = {28'h0000000, evt_enable};
         `HRBS_OFS_THRESHOLD:  next_prdata = {25'h0000000, second_harmonic_threshold};
         `HRBS_OFS_DELAY:      next_prdata = {17'h00000, inrush_operate_delay};
         `HRBS_OFS_STATUS:     next_prdata = {24'h000000, HARM_CODE, 2'b00,
                                              trip_out, start_out};
         `HRBS_OFS_EVENTS:     next_prdata = {28'h0000000, events};
         `HRBS_OFS_PHASE_A:    next_prdata = {16'h0000, phase_a_pct};
         `HRBS_OFS_PHASE_B:    next_prdata = {16'h0000, phase_b_pct};
         `HRBS_OFS_PHASE_C:    next_prdata = {16'h0000, phase_c_pct};
         `HRBS_OFS_FAULT_MAX:  next_prdata = {16'h0000, fault_max_pct};
         `HRBS_OFS_ELAPSED:    next_prdata = {16'h0000, elapsed_delay_pct};
         default:              next_err    = 1'b1;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & next_err;
         // Cleared after every access, also when a setup follows back to back
         if (psel && !penable && !pwrite)
            prdata <= next_prdata;
         else
            prdata <= 32'h00000000;
      end
   end

endmodule // hrbs_stage

/* dv/hrbs_stage_sva.sv */
// Purpose: Port assertions for hrbs_stage
// Assumes: One pclk domain, async active-low reset
// Notes:   Bound into every hrbs_stage instance
`timescale 1ns/100ps

module hrbs_stage_sva #(
   parameter TICK_CYCLES = 4
) (
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire [31:0] prdata,
   input wire        pslverr,
   // Stage outputs
   input wire        start_out,
   input wire        trip_out,
   input wire        evt_start_on
);
   reg [31:0] run_cyc;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////////
   // Cycles of start, so the shortest legal delay bounds the first trip
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         run_cyc <= 32'h0;
      else if (!start_out)
         run_cyc <= 32'h0;
      else
         run_cyc <= run_cyc + 32'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   a_pready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_pready_has_cause: assert property (pready |-> $past(psel && !penable))
      else $error("pready without setup");
   a_slverr_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside access");
   a_prdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero when idle");
   a_trip_needs_start: assert property (trip_out |-> start_out)
      else $error("trip without start");
   a_trip_min_delay: assert property ($rose(trip_out) |-> run_cyc >= 5 * TICK_CYCLES - 2)
      else $error("trip before shortest delay");
   a_release_both: assert property ($fell(start_out) |-> !trip_out)
      else $error("trip held after start release");
   a_evt_one_cycle: assert property (evt_start_on |=> !evt_start_on)
      else $error("start event longer than one cycle");
endmodule // hrbs_stage_sva

bind hrbs_stage hrbs_stage_sva #(.TICK_CYCLES(TICK_CYCLES)) hrbs_stage_sva_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .start_out(start_out), .trip_out(trip_out),
   .evt_start_on(evt_start_on));

/* dv/hrbs_meas_src.sv */
// Purpose: Harmonic measurement source in front of the stage
// Assumes: Caller spaces samples beyond the divider busy time
// Notes:   Lines invert after the strobe so stale data is never trusted
`timescale 1ns/100ps

module hrbs_meas_src (
   // Clock
   input  wire        pclk,
   // Sample
   output reg         meas_valid,
   output reg  [15:0] harm_a,
   output reg  [15:0] harm_b,
   output reg  [15:0] harm_c,
   output reg  [15:0] fund_a,
   output reg  [15:0] fund_b,
   output reg  [15:0] fund_c
);
   initial begin
      meas_valid = 1'b0;
      {harm_a, harm_b, harm_c, fund_a, fund_b, fund_c} = 96'h0;
   end

   // Sample word is {ha, hb, hc, fa, fb, fc}
   task send(input [95:0] s);
      begin
         @(posedge pclk);
         meas_valid <= 1'b1;
         {harm_a, harm_b, harm_c, fund_a, fund_b, fund_c} <= s;
         @(posedge pclk);
         meas_valid <= 1'b0;
         {harm_a, harm_b, harm_c, fund_a, fund_b, fund_c} <= ~s;
         // Divider stays busy 24 cycles; a strobe inside is dropped
         repeat (26) @(posedge pclk);
      end
   endtask
endmodule // hrbs_meas_src

/* dv/tb_harmonic_ratio_blocking_stage.sv */
// Purpose: Self-checking bench for hrbs_stage
// Assumes: Zero-wait APB slave, short tick parameter
// Notes:   Random ratios plus fault, release and event corner cases
`timescale 1ns/100ps

module tb_harmonic_ratio_blocking_stage;
   localparam TICK = 4;
   reg         pclk, presetn, psel, penable, pwrite, err;
   reg  [7:0]  paddr, p;
   reg  [31:0] pwdata, rd;
   reg  [15:0] h [0:2];
   reg  [15:0] f [0:2];
   wire        pready, pslverr, meas_valid, start_out, trip_out;
   wire [31:0] prdata;
   wire [15:0] harm_a, harm_b, harm_c, fund_a, fund_b, fund_c;
   wire [3:0]  evt;
   integer     num_errors, n_compared, wc, i, k, m, seed;
   integer     ec [0:3];

   hrbs_stage #(.HARMONIC(2), .TICK_CYCLES(TICK)) hrbs_stage_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .meas_valid(meas_valid), .harm_a(harm_a), .harm_b(harm_b), .harm_c(harm_c),
      .fund_a(fund_a), .fund_b(fund_b), .fund_c(fund_c), .start_out(start_out),
      .trip_out(trip_out), .evt_start_on(evt[0]), .evt_start_off(evt[1]),
      .evt_trip_on(evt[2]), .evt_trip_off(evt[3]));
   hrbs_meas_src hrbs_meas_src_i (
      .pclk(pclk), .meas_valid(meas_valid), .harm_a(harm_a), .harm_b(harm_b),
      .harm_c(harm_c), .fund_a(fund_a), .fund_b(fund_b), .fund_c(fund_c));

   always #2.5 pclk = ~pclk;
   always @(posedge pclk)
      for (m = 0; m < 4; m = m + 1)
         if (evt[m] === 1'b1) ec[m] = ec[m] + 1;

   ////////////////////////////////////////////////////////////////////////////////
   function [31:0] pct(input [15:0] hv, input [15:0] fv);
      reg [31:0] q;
      begin
         q = (fv == 16'h0) ? 32'h0 : (hv * 32'h64) / fv;
         pct = (q > 32'hFFFF) ? 32'hFFFF : q;
      end
   endfunction

   task conclude;
      begin
         $display("compared %0d, mismatches %0d", n_compared, num_errors);
         if (num_errors == 0 && n_compared > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   task chk(input [8*12-1:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask

   // Held until pready is sampled high; data taken at that edge only
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
         @(posedge pclk);
         penable <= 1'b1;
         wc = 0;
         do begin
            @(posedge pclk);
            wc = wc + 1;
         end while (pready !== 1'b1 && wc < 50);
         rd = prdata;
         err = pslverr;
         {psel, penable} <= 2'b00;
         if (wc >= 50) begin
            chk("apb_wait", 0, 1);
            conclude;
         end
      end
   endtask

   task rdchk(input [8*12-1:0] nm, input [7:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(nm, rd, exp);
      end
   endtask

   // Count edges until start (sel 0) or trip (sel 1) reads val
   task waitfor(input sel, input val);
      begin
         wc = 0;
         while (((sel ? trip_out : start_out) !== val) && wc < 400) begin
            @(posedge pclk);
            wc = wc + 1;
         end
         if (wc >= 400) begin
            chk("wait_level", 0, 1);
            conclude;
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 45'h0;
      num_errors = 0;
      n_compared = 0;
      for (k = 0; k < 4; k = k + 1) ec[k] = 0;
      seed = $urandom(32'h4C480568);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("evt_enable", 8'h00, 32'hF);
      rdchk("threshold", 8'h04, 32'hA);
      rdchk("delay", 8'h08, 32'h5);
      rdchk("status", 8'h0C, 32'h20);
      rdchk("unmapped", 8'h28, 32'h0);
      chk("slverr", err, 1);
      $display("test reset done");
      // Out-of-range settings are ignored, the threshold limit is taken
      apb(1'b1, 8'h04, 32'h9);
      apb(1'b1, 8'h04, 32'h65);
      rdchk("thr_range", 8'h04, 32'hA);
      apb(1'b1, 8'h04, 32'h64);
      rdchk("thr_max", 8'h04, 32'h64);
      apb(1'b1, 8'h08, 32'h4);
      apb(1'b1, 8'h08, 32'h7531);
      rdchk("dly_range", 8'h08, 32'h5);
      apb(1'b1, 8'h08, 32'h6);
      rdchk("dly_set", 8'h08, 32'h6);
      $display("test limits done");
      // Random sub-threshold ratios; 100 percent equal to threshold and zero fundamental
      for (i = 0; i < 3; i = i + 1) begin
         for (k = 0; k < 3; k = k + 1) begin
            f[k] = $urandom % 16'hFFFF + 16'h1;
            h[k] = $urandom % f[k];
         end
         if (i == 0) begin
            h[0] = f[0];
            f[2] = 16'h0;
         end
         hrbs_meas_src_i.send({h[0], h[1], h[2], f[0], f[1], f[2]});
         for (p = 0; p < 3; p = p + 1)
            rdchk("phase_pct", 8'h14 + p * 8'h4, pct(h[p], f[p]));
         chk("no_start", start_out, 0);
      end
      $display("test ratios done");
      // Fault with a saturated phase, trip, then release
      hrbs_meas_src_i.send({16'h0032, 16'hFFFF, 16'h0000, 16'h0064, 16'h0001, 16'h0000});
      waitfor(1'b0, 1'b1);
      // A blocked stage waits over 60 ms, six ticks; the block must come first
      chk("block_lead", wc < 6 * TICK, 1);
      waitfor(1'b1, 1'b1);
      chk("trip_delay", (wc >= 6 * TICK - 2) && (wc <= 6 * TICK + 4), 1);
      rdchk("status", 8'h0C, 32'h23);
      rdchk("phase_sat", 8'h18, 32'hFFFF);
      hrbs_meas_src_i.send({16'h0001, 16'h0001, 16'h0001, 16'h0064, 16'h0064, 16'h0064});
      waitfor(1'b0, 1'b0);
      chk("trip_rel", trip_out, 0);
      repeat (30) @(posedge pclk);
      rdchk("fault_max", 8'h20, 32'hFFFF);
      rdchk("elapsed", 8'h24, 32'h64);
      rdchk("events", 8'h10, 32'hF);
      apb(1'b1, 8'h10, 32'hF);
      rdchk("evt_clear", 8'h10, 32'h0);
      for (k = 0; k < 4; k = k + 1) begin
         chk("evt_pulses", ec[k], 1);
         ec[k] = 0;
      end
      $display("test trip done");
      // Start event disabled; release before a long delay leaves trip idle
      apb(1'b1, 8'h00, 32'hE);
      apb(1'b1, 8'h08, 32'h7530);
      hrbs_meas_src_i.send({16'h00C8, 16'h0000, 16'h0000, 16'h0064, 16'h0064, 16'h0064});
      waitfor(1'b0, 1'b1);
      hrbs_meas_src_i.send({16'h0001, 16'h0001, 16'h0001, 16'h0064, 16'h0064, 16'h0064});
      waitfor(1'b0, 1'b0);
      repeat (30) @(posedge pclk);
      chk("son_masked", ec[0], 0);
      chk("soff_pulse", ec[1], 1);
      chk("no_trip", ec[2], 0);
      rdchk("elapsed", 8'h24, 32'h0);
      rdchk("fault_max", 8'h20, 32'hC8);
      $display("test release done");
      conclude;
   end
endmodule // tb_harmonic_ratio_blocking_stage
